// *** hw/fwg_map.vh ***
`ifndef FWG_MAP_VH
`define FWG_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets on the plain register port
// ----------------------------------------------------------------------------
`define FWG_OFS_CMD        8'h00
`define FWG_OFS_DATA       8'h01
`define FWG_OFS_KEY        8'h02
`define FWG_OFS_FUNC       8'h03
`define FWG_OFS_ADDR_HI    8'h04
`define FWG_OFS_ADDR_LO    8'h05
`define FWG_OFS_ARG        8'h06
`define FWG_OFS_COUNT      8'h07
`define FWG_OFS_STATUS     8'h08
`define FWG_OFS_ERROR      8'h09
`define FWG_OFS_MODE       8'h0a
`define FWG_OFS_CFG_BASE   8'h10

// ----------------------------------------------------------------------------
// Key, command and function codes
// ----------------------------------------------------------------------------
`define FWG_KEY_VALUE      8'h96
`define FWG_CMD_SET_WE     8'h08
`define FWG_CMD_CLR_WE     8'h0b
`define FWG_FN_PROG_PAGE   8'h00
`define FWG_FN_VERSION     8'h01
`define FWG_FN_MISC_WRITE  8'h02
`define FWG_FN_MISC_READ   8'h03
`define FWG_FN_ERASE       8'h04
`define FWG_FN_SECTOR_CRC  8'h05
`define FWG_FN_GLOBAL_CRC  8'h06
`define FWG_SEL_ERASE_PAGE 8'h00
`define FWG_SEL_ERASE_SECT 8'h01
`define FWG_TGT_CCP        8'h10
`define FWG_TGT_CFG_LAST   8'h03
`define FWG_TGT_SEC_FIRST  8'h08
`define FWG_TGT_SEC_LAST   8'h0f
`define FWG_TGT_BOOT_STATUS_BYTE   4'h3

// ----------------------------------------------------------------------------
// Field positions and modes
// ----------------------------------------------------------------------------
`define FWG_BIT_GUARD      7
`define FWG_BIT_CWP        6
`define FWG_ERR_OI         0
`define FWG_ERR_SV         1
`define FWG_ERR_HVE        2
`define FWG_ERR_VE         3
`define FWG_MODE_APP       2'h0
`define FWG_MODE_SERIAL    2'h1
`define FWG_MODE_ICP       2'h2
`define FWG_MODE_PARALLEL  2'h3
`define FWG_VERSION_ID     8'h01
`define FWG_CFG_RESET      8'h00

`endif

// *** hw/fwg_top.v ***
// Overview of operation
// - Key is cleared after each processed call.
// - Keyed call without valid key resets MCU.
// - Write guard only in application mode; serial boot bypasses it.
// - Guard bit zero forces write-enable flag set.
// - Command 08H then key sets write-enable.
// - Command 0BH then key, or reset, clears it.
// - Boot sets flag; flag cleared after writes.
// - Config protect bit refuses config writes in serial-boot and application modes.
// - Protect set by boot status; cleared by command.
// - Disable bit blocks clear command except programmer modes.
// - CPU held program-idle during self-timed cycles.
// - Interrupt aborts cycle, sets carry and status.
// - Status bit 0 marks interrupted operation.
// - Status bit 1 marks security violation.
// - Status bit 2 marks high-voltage fault.
// - Status bit 3 marks read-back mismatch.
// - Error register bits 4 to 7 read zero.
// - Code 00h programs a user code page.
// - Code 02h writes config, security, or clears protect.
// - Code 04h erases page or sector, keyed.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`include "fwg_map.vh"
`default_nettype none

module fwg_top
(
   // Clock and reset
   input  wire       clk,
   input  wire       resetn,
   // Register port
   input  wire [7:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr_stb,
   input  wire       rd_stb,
   output reg  [7:0] rdata,
   // Flash engine
   output reg        op_start,
   output reg        op_abort,
   output reg  [7:0] op_func,
   output reg  [15:0] op_addr,
   output reg  [7:0] op_arg,
   output reg  [7:0] op_count,
   input  wire       op_done,
   input  wire       hv_fault,
   input  wire       sec_block,
   input  wire       verify_mismatch,
   // Processor side
   input  wire       irq_pending,
   output reg        cpu_idle,
   output reg        mcu_reset_req
);

   // -------------------------------------------------------------------------
   // Helper functions
   // -------------------------------------------------------------------------

   // Calls that write or erase code memory need the key.
   function is_keyed;
      input [7:0] fn;
      begin
         is_keyed = (fn == `FWG_FN_PROG_PAGE) || (fn == `FWG_FN_MISC_WRITE) ||
                    (fn == `FWG_FN_ERASE);
      end
   endfunction

   // Configuration targets are the four bytes at the bottom of the map.
   function is_cfg_target;
      input [7:0] t;
      begin
         is_cfg_target = (t <= `FWG_TGT_CFG_LAST);
      end
   endfunction

   // Targets that exist at all; a write to a reserved one is a violation, a read returns zero.
   function is_valid_target;
      input [7:0] t;
      begin
         is_valid_target = (t <= `FWG_TGT_CFG_LAST) ||
                           ((t >= `FWG_TGT_SEC_FIRST) && (t <= `FWG_TGT_SEC_LAST));
      end
   endfunction

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   localparam ST_IDLE = 1'b0;
   localparam ST_BUSY = 1'b1;

   reg        state_reg;
   reg [7:0]  cmd_reg;
   reg [7:0]  key_reg;
   reg [7:0]  addr_hi_reg;
   reg [7:0]  addr_lo_reg;
   reg [7:0]  arg_reg;
   reg [7:0]  count_reg;
   reg [1:0]  mode_reg;
   reg        we_reg;
   reg        carry_reg;
   reg [3:0]  err_reg;
   reg [7:0]  result_reg;
   reg [7:0]  cfg_mem [0:15];
   integer    i;

   // The guard and the disable-clear control share one boot status bit.
   wire [7:0] boot_status_byte   = cfg_mem[`FWG_TGT_BOOT_STATUS_BYTE];
   wire       activate_write_guard = boot_status_byte[`FWG_BIT_GUARD];
   wire       disable_clear_protection = boot_status_byte[`FWG_BIT_GUARD];
   wire       config_write_protect = boot_status_byte[`FWG_BIT_CWP];
   wire       guarded_mode = (mode_reg == `FWG_MODE_APP) ||
                             (mode_reg == `FWG_MODE_SERIAL);
   wire       we_effective = ~activate_write_guard | we_reg;
   wire       wr_cmd   = wr_stb && (addr == `FWG_OFS_CMD);
   wire       wr_data  = wr_stb && (addr == `FWG_OFS_DATA);
   wire       wr_func  = wr_stb && (addr == `FWG_OFS_FUNC) && (state_reg == ST_IDLE);
   wire       key_ok   = (key_reg == `FWG_KEY_VALUE);
   wire       flag_key = wr_data && (wdata == `FWG_KEY_VALUE);
   wire       is_ccp   = (arg_reg == `FWG_TGT_CCP);
   wire       is_write = (wdata == `FWG_FN_PROG_PAGE) || (wdata == `FWG_FN_MISC_WRITE) ||
                         (wdata == `FWG_FN_ERASE);

   // -------------------------------------------------------------------------
   // Call acceptance
   // -------------------------------------------------------------------------

   // Write permission comes from the flag, from a programmer mode that the
   // guard never covers, or from serial boot, which sets the flag as a call starts.
   reg  call_we_ok;
   reg  call_refused;
   reg  call_run;
   always @*
   begin
      call_we_ok   = we_effective || !guarded_mode ||
                     (mode_reg == `FWG_MODE_SERIAL);
      call_refused = 1'b0;
      call_run     = 1'b0;
      if (wdata == `FWG_FN_MISC_WRITE)
      begin
         if (is_ccp)
            call_refused = disable_clear_protection && guarded_mode;
         else
            call_refused = !call_we_ok || !is_valid_target(arg_reg) ||
                           (is_cfg_target(arg_reg) && config_write_protect &&
                            guarded_mode);
         call_run = !call_refused && !is_ccp;
      end
      else if ((wdata == `FWG_FN_PROG_PAGE) || (wdata == `FWG_FN_ERASE))
      begin
         call_refused = !call_we_ok;
         call_run     = call_we_ok;
      end
      else if ((wdata == `FWG_FN_SECTOR_CRC) || (wdata == `FWG_FN_GLOBAL_CRC))
         call_run = 1'b1;
   end

   // -------------------------------------------------------------------------
   // Sequencer, flags and configuration store
   // -------------------------------------------------------------------------

   // One process owns the call state so that a command write and a call
   // completing in the same cycle settle in a single, defined order.
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg     <= ST_IDLE;
         cmd_reg       <= 8'h00;
         key_reg       <= 8'h00;
         addr_hi_reg   <= 8'h00;
         addr_lo_reg   <= 8'h00;
         arg_reg       <= 8'h00;
         count_reg     <= 8'h00;
         mode_reg      <= `FWG_MODE_APP;
         we_reg        <= 1'b0;
         carry_reg     <= 1'b0;
         err_reg       <= 4'h0;
         result_reg    <= 8'h00;
         op_start      <= 1'b0;
         op_abort      <= 1'b0;
         op_func       <= 8'h00;
         op_addr       <= 16'h0000;
         op_arg        <= 8'h00;
         op_count      <= 8'h00;
         cpu_idle      <= 1'b0;
         mcu_reset_req <= 1'b0;
         for (i = 0; i < 16; i = i + 1)
            cfg_mem[i] <= `FWG_CFG_RESET;
      end
      else
      begin
         op_start      <= 1'b0;
         op_abort      <= 1'b0;
         mcu_reset_req <= 1'b0;

         // Plain parameter registers.
         if (wr_stb && (addr == `FWG_OFS_CMD))
            cmd_reg <= wdata;
         if (wr_stb && (addr == `FWG_OFS_KEY))
            key_reg <= wdata;
         if (wr_stb && (addr == `FWG_OFS_ADDR_HI))
            addr_hi_reg <= wdata;
         if (wr_stb && (addr == `FWG_OFS_ADDR_LO))
            addr_lo_reg <= wdata;
         if (wr_stb && (addr == `FWG_OFS_ARG))
            arg_reg <= wdata;
         if (wr_stb && (addr == `FWG_OFS_COUNT))
            count_reg <= wdata;
         if (wr_stb && (addr == `FWG_OFS_MODE))
            mode_reg <= wdata[1:0];

         // The command must already be latched when the key arrives.
         // A key with no matching latched command leaves the flag as it is.
         if (flag_key && !wr_cmd && (cmd_reg == `FWG_CMD_SET_WE))
            we_reg <= 1'b1;
         if (flag_key && !wr_cmd && (cmd_reg == `FWG_CMD_CLR_WE))
            we_reg <= 1'b0;

         case (state_reg)
            ST_IDLE:
            begin
               if (wr_func)
               begin
                  key_reg <= 8'h00;
                  if (is_keyed(wdata) && !key_ok)
                     mcu_reset_req <= 1'b1;
                  else if (call_run)
                  begin
                     state_reg <= ST_BUSY;
                     cpu_idle  <= 1'b1;
                     op_start  <= 1'b1;
                     op_func   <= wdata;
                     op_addr   <= {addr_hi_reg, addr_lo_reg};
                     op_arg    <= (wdata == `FWG_FN_ERASE) ?
                                  {7'h00, arg_reg[0]} : arg_reg;
                     op_count  <= count_reg;
                     carry_reg <= 1'b0;
                     err_reg   <= 4'h0;
                     if (mode_reg == `FWG_MODE_SERIAL)
                        we_reg <= 1'b1;
                  end
                  else if (call_refused)
                  begin
                     // A refused call never reaches the engine, so memory stays intact.
                     carry_reg  <= 1'b1;
                     err_reg    <= 4'h0;
                     err_reg[`FWG_ERR_SV] <= 1'b1;
                     result_reg <= 8'h02;
                     if (is_write)
                        we_reg <= 1'b0;
                  end
                  else
                  begin
                     // Calls answered at once, without an engine cycle.
                     carry_reg <= 1'b0;
                     err_reg   <= 4'h0;
                     if ((wdata == `FWG_FN_MISC_WRITE) && is_ccp)
                     begin
                        // Clearing protection; programmer modes also drop
                        // the disable bit.
                        cfg_mem[`FWG_TGT_BOOT_STATUS_BYTE][`FWG_BIT_CWP] <= 1'b0;
                        if (!guarded_mode)
                           cfg_mem[`FWG_TGT_BOOT_STATUS_BYTE][`FWG_BIT_GUARD] <= 1'b0;
                        we_reg     <= 1'b0;
                        result_reg <= 8'h00;
                     end
                     else if (wdata == `FWG_FN_MISC_READ)
                        result_reg <= is_valid_target(arg_reg) ?
                                      cfg_mem[arg_reg[3:0]] : 8'h00;
                     else if (wdata == `FWG_FN_VERSION)
                        result_reg <= `FWG_VERSION_ID;
                     else
                        result_reg <= 8'h00;
                  end
               end
            end
            ST_BUSY:
            begin
               // An interrupt takes priority so that the processor can
               // leave program-idle and fetch its handler at once.
               if (irq_pending)
               begin
                  state_reg  <= ST_IDLE;
                  cpu_idle   <= 1'b0;
                  op_abort   <= 1'b1;
                  carry_reg  <= 1'b1;
                  err_reg    <= 4'h1;
                  result_reg <= 8'h01;
                  if (is_keyed(op_func))
                     we_reg <= 1'b0;
               end
               else if (sec_block || hv_fault)
               begin
                  // A fault ends the cycle at once; the array is left as the engine left it.
                  state_reg  <= ST_IDLE;
                  cpu_idle   <= 1'b0;
                  op_abort   <= 1'b1;
                  carry_reg  <= 1'b1;
                  err_reg    <= {1'b0, hv_fault, sec_block, 1'b0};
                  result_reg <= {5'h00, hv_fault, sec_block, 1'b0};
                  if (is_keyed(op_func))
                     we_reg <= 1'b0;
               end
               else if (op_done)
               begin
                  state_reg <= ST_IDLE;
                  cpu_idle  <= 1'b0;
                  if (is_keyed(op_func))
                     we_reg <= 1'b0;
                  if ((op_func == `FWG_FN_PROG_PAGE) && verify_mismatch)
                  begin
                     carry_reg  <= 1'b1;
                     err_reg    <= 4'h8;
                     result_reg <= 8'h08;
                  end
                  else
                  begin
                     carry_reg  <= 1'b0;
                     result_reg <= 8'h00;
                     // The store changes only once the engine reports a clean end.
                     if (op_func == `FWG_FN_MISC_WRITE)
                        cfg_mem[op_arg[3:0]] <= op_count;
                  end
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
               cpu_idle  <= 1'b0;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Read port
   // -------------------------------------------------------------------------

   // Read data stand in the cycle after the strobe only; idle cycles and
   // unmapped offsets return zero so the master never sees stale data.
   // The store owns a whole aligned block of sixteen offsets, so only the
   // upper nibble of the offset selects it.
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
         rdata <= 8'h00;
      else if (!rd_stb)
         rdata <= 8'h00;
      else if ((addr & 8'hf0) == `FWG_OFS_CFG_BASE)
         rdata <= cfg_mem[addr[3:0]];
      else
      begin
         case (addr)
            `FWG_OFS_CMD:     rdata <= cmd_reg;
            `FWG_OFS_KEY:     rdata <= key_reg;
            `FWG_OFS_FUNC:    rdata <= result_reg;
            `FWG_OFS_ADDR_HI: rdata <= addr_hi_reg;
            `FWG_OFS_ADDR_LO: rdata <= addr_lo_reg;
            `FWG_OFS_ARG:     rdata <= arg_reg;
            `FWG_OFS_COUNT:   rdata <= count_reg;
            `FWG_OFS_STATUS:  rdata <= {state_reg, we_effective, carry_reg, 1'b0, err_reg};
            `FWG_OFS_ERROR:   rdata <= {4'h0, err_reg};
            `FWG_OFS_MODE:    rdata <= {6'h00, mode_reg};
            default:          rdata <= 8'h00;
         endcase
      end
   end

endmodule

`default_nettype wire

// *** tb/fwg_engine_model.sv ***
`default_nettype none
module fwg_engine_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Guard side
   input  wire logic       op_start,
   input  wire logic       cpu_idle,
   // Outcome: 0 ok, 1 wait for irq, 2 security, 3 high voltage, 4 verify
   input  wire logic [2:0] kind,
   input  wire logic [7:0] lat,
   // Engine answers
   output var  logic       op_done,
   output var  logic       hv_fault,
   output var  logic       sec_block,
   output var  logic       verify_mismatch
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       busy;
   logic [7:0] cnt;
   // Self-timed cycle; faults stay raised until the guard leaves idle.
   // The mismatch line wanders outside op_done, so a stray sample shows up.
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         {busy, op_done, hv_fault, sec_block, verify_mismatch} <= 5'h00;
         cnt <= 8'h00;
      end
      else
      begin
         op_done <= 1'b0;
         verify_mismatch <= ~verify_mismatch;
         if (op_start)
         begin
            busy <= 1'b1;
            cnt <= lat;
         end
         else if (busy && !cpu_idle)
         begin
            busy <= 1'b0;
            {hv_fault, sec_block} <= 2'h0;
         end
         else if (busy && cnt != 8'h00)
            cnt <= cnt - 8'h01;
         else if (busy)
         begin
            sec_block <= kind == 3'd2;
            hv_fault <= kind == 3'd3;
            op_done <= kind == 3'd0 || kind == 3'd4;
            verify_mismatch <= kind == 3'd4;
            busy <= kind != 3'd0 && kind != 3'd4;
         end
      end
endmodule
`default_nettype wire

// *** tb/fwg_top_asserts.sv ***
`include "fwg_map.vh"
`default_nettype none
module fwg_checker (
   // Clock and reset
   input wire logic       clk,
   input wire logic       resetn,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rdata,
   // Engine and processor side
   input wire logic       op_start,
   input wire logic       op_abort,
   input wire logic [7:0] op_func,
   input wire logic       op_done,
   input wire logic       hv_fault,
   input wire logic       sec_block,
   input wire logic       irq_pending,
   input wire logic       cpu_idle,
   input wire logic       mcu_reset_req
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------
   // Key shadow
   // ------
   logic key_ok;
   wire  fn_wr = wr_stb && addr == `FWG_OFS_FUNC && !cpu_idle;
   wire  keyed = wdata == 8'h00 || wdata == 8'h02 || wdata == 8'h04;
   // A function write uses up the key even when the call is refused.
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         key_ok <= 1'b0;
      else if (wr_stb && addr == `FWG_OFS_KEY)
         key_ok <= wdata == `FWG_KEY_VALUE;
      else if (fn_wr)
         key_ok <= 1'b0;
   default clocking dclk @(posedge clk); endclocking
   default disable iff (!resetn);
   // ------
   // Properties
   // ------
   property p_start_idle; op_start |-> cpu_idle; endproperty
   property p_idle_hold;
      cpu_idle && !op_done && !irq_pending && !hv_fault && !sec_block |=> cpu_idle;
   endproperty
   property p_done_end; cpu_idle && op_done |=> !cpu_idle; endproperty
   property p_irq_abort; cpu_idle && irq_pending |=> op_abort && !cpu_idle; endproperty
   property p_fault_end; cpu_idle && (hv_fault || sec_block) |=> !cpu_idle; endproperty
   property p_no_key; fn_wr && keyed && !key_ok |=> mcu_reset_req ##1 !mcu_reset_req; endproperty
   property p_key_ok; fn_wr && key_ok |=> !mcu_reset_req; endproperty
   property p_err_hi; rd_stb && addr == `FWG_OFS_ERROR |=> rdata[7:4] == 4'h0; endproperty
   property p_start_src; op_start |-> $past(fn_wr) && op_func == $past(wdata); endproperty
   a_start_idle: assert property (p_start_idle) else $error("start without idle");
   a_idle_hold: assert property (p_idle_hold) else $error("idle dropped early");
   a_done_end: assert property (p_done_end) else $error("idle kept after done");
   a_irq_abort: assert property (p_irq_abort) else $error("irq did not abort");
   a_fault_end: assert property (p_fault_end) else $error("fault kept idle");
   a_no_key: assert property (p_no_key) else $error("missing key no reset");
   a_key_ok: assert property (p_key_ok) else $error("reset with valid key");
   a_err_hi: assert property (p_err_hi) else $error("error upper bits set");
   a_start_src: assert property (p_start_src) else $error("bad start cause");
   c_irq: cover property (cpu_idle && irq_pending);
   c_done: cover property (cpu_idle && op_done);
   c_reset: cover property (mcu_reset_req);
endmodule
bind fwg_top fwg_checker u_chk (
   .clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .op_start, .op_abort,
   .op_func, .op_done, .hv_fault, .sec_block, .irq_pending, .cpu_idle, .mcu_reset_req
);
`default_nettype wire

// *** tb/test_fwg_top.sv ***
`include "fwg_map.vh"
`default_nettype none
module test_fwg_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, resetn, wr_stb, rd_stb, irq_pending, op_start, op_abort, op_done;
   logic        hv_fault, sec_block, verify_mismatch, cpu_idle, mcu_reset_req;
   logic [7:0]  addr, wdata, rdata, op_func, op_arg, op_count, lat, st, gf, ga, gc;
   logic [15:0] op_addr, gad;
   logic [2:0]  kind;
   int          n_fail, comparisons, n_start, i;
   fwg_top u_dut (
      .clk, .resetn, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .op_start, .op_abort,
      .op_func, .op_addr, .op_arg, .op_count, .op_done, .hv_fault, .sec_block,
      .verify_mismatch, .irq_pending, .cpu_idle, .mcu_reset_req
   );
   fwg_engine_model u_eng (
      .clk, .resetn, .op_start, .cpu_idle, .kind, .lat, .op_done, .hv_fault,
      .sec_block, .verify_mismatch
   );
   // Free-running clock.
   always #25 clk = ~clk;
   // Snapshot what the guard hands the engine at each start.
   always @(posedge clk)
      if (op_start === 1'b1)
      begin
         n_start++;
         {gf, ga, gc, gad} <= {op_func, op_arg, op_count, op_addr};
      end
   // ------
   // Tasks
   // ------
   task automatic chk(input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge clk);
      {addr, wdata, wr_stb} <= {a, d, 1'b1};
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe.
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      {addr, rd_stb} <= {a, 1'b1};
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      st = rdata;
   endtask
   task automatic crd(input logic [7:0] a, exp);
      rd(a);
      chk(st, exp);
   endtask
   function automatic logic [7:0] sexp(input logic we, input logic [3:0] e);
      return {1'b0, we, |e, 1'b0, e};
   endfunction
   // Keyed call: optional write enable, arguments, key, wait, then status in st.
   task automatic kcall(input logic [7:0] fn, arg, dat, input bit arm, input logic [2:0] k);
      logic [15:0] a;
      int          s0;
      a = 16'($urandom);
      s0 = n_start;
      kind <= k;
      lat <= (k == 3'd1) ? 8'h28 : 8'($urandom_range(1, 12));
      if (arm)
      begin
         wr(`FWG_OFS_CMD, `FWG_CMD_SET_WE);
         wr(`FWG_OFS_DATA, `FWG_KEY_VALUE);
      end
      wr(`FWG_OFS_ADDR_HI, a[15:8]);
      wr(`FWG_OFS_ADDR_LO, a[7:0]);
      wr(`FWG_OFS_ARG, arg);
      wr(`FWG_OFS_COUNT, dat);
      wr(`FWG_OFS_KEY, `FWG_KEY_VALUE);
      wr(`FWG_OFS_FUNC, fn);
      if (k == 3'd1)
         repeat (3) @(posedge clk);
      irq_pending <= k == 3'd1;
      @(negedge clk);
      for (int n = 0; n < 99 && cpu_idle !== 1'b0; n++)
         @(negedge clk);
      @(posedge clk);
      irq_pending <= 1'b0;
      if (n_start != s0)
      begin
         chk(gf, fn);
         chk(ga, arg);
         chk(gc, dat);
         chk(gad[15:8], a[15:8]);
         chk(gad[7:0], a[7:0]);
      end
      rd(`FWG_OFS_STATUS);
   endtask
   task automatic done(input string name);
      $display("test %s finished", name);
   endtask
   task automatic summarize();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ------
   // Sequence
   // ------
   initial
   begin
      {clk, resetn, wr_stb, rd_stb, irq_pending, addr, wdata, kind, lat} = '0;
      void'($urandom(10418));
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      crd(`FWG_OFS_STATUS, 8'h40);
      crd(`FWG_OFS_ERROR, 8'h00);
      done("reset");
      kcall(`FWG_FN_MISC_WRITE, 8'h03, 8'h80, 1'b0, 3'd0);
      chk(st, 8'h00);
      crd(`FWG_OFS_CFG_BASE + 8'h03, 8'h80);
      kcall(`FWG_FN_PROG_PAGE, 8'h00, 8'($urandom), 1'b0, 3'd0);
      chk(st, 8'h22);
      wr(`FWG_OFS_CMD, `FWG_CMD_SET_WE);
      // Carry and error of the refused call stand until the next accepted call.
      wr(`FWG_OFS_DATA, 8'($urandom_range(0, 149)));
      crd(`FWG_OFS_STATUS, 8'h22);
      wr(`FWG_OFS_DATA, `FWG_KEY_VALUE);
      crd(`FWG_OFS_STATUS, 8'h62);
      wr(`FWG_OFS_CMD, `FWG_CMD_CLR_WE);
      wr(`FWG_OFS_DATA, `FWG_KEY_VALUE);
      crd(`FWG_OFS_STATUS, 8'h22);
      done("write enable");
      // Outcomes from verify error down to success; the last pass programs a fresh page cleanly.
      for (i = 4; i >= 0; i--)
      begin
         kcall(`FWG_FN_PROG_PAGE, 8'h00, 8'($urandom), 1'b1, 3'(i));
         chk(st, sexp(1'b0, (i == 0) ? 4'h0 : 4'(1 << (i - 1))));
         crd(`FWG_OFS_ERROR, (i == 0) ? 8'h00 : 8'(1 << (i - 1)));
      end
      for (i = 0; i < 2; i++)
      begin
         kcall(`FWG_FN_ERASE, 8'(i), 8'h00, 1'b1, 3'd0);
         chk(st, 8'h00);
      end
      // A CRC cycle is aborted by an interrupt just like a program cycle.
      kcall(`FWG_FN_SECTOR_CRC, 8'h04, 8'h00, 1'b0, 3'd1);
      chk(st, sexp(1'b0, 4'h1));
      done("engine");
      kcall(`FWG_FN_MISC_WRITE, 8'h03, 8'hc0, 1'b1, 3'd0);
      kcall(`FWG_FN_MISC_WRITE, 8'h00, 8'h5a, 1'b1, 3'd0);
      chk(st, 8'h22);
      crd(`FWG_OFS_CFG_BASE, 8'h00);
      kcall(`FWG_FN_MISC_WRITE, `FWG_TGT_CCP, 8'h00, 1'b1, 3'd0);
      chk(st, 8'h22);
      wr(`FWG_OFS_MODE, 8'h02);
      kcall(`FWG_FN_MISC_WRITE, 8'h00, 8'h5a, 1'b0, 3'd0);
      crd(`FWG_OFS_CFG_BASE, 8'h5a);
      wr(`FWG_OFS_MODE, 8'h03);
      kcall(`FWG_FN_MISC_WRITE, `FWG_TGT_CCP, 8'h00, 1'b0, 3'd0);
      crd(`FWG_OFS_CFG_BASE + 8'h03, 8'h00);
      // Serial boot bypasses the flag, so an unarmed page call still runs.
      wr(`FWG_OFS_MODE, 8'h01);
      kcall(`FWG_FN_MISC_WRITE, 8'h03, 8'h80, 1'b0, 3'd0);
      kcall(`FWG_FN_PROG_PAGE, 8'h00, 8'($urandom), 1'b0, 3'd0);
      chk(st, 8'h00);
      kcall(`FWG_FN_MISC_READ, 8'h03, 8'h00, 1'b0, 3'd0);
      crd(`FWG_OFS_FUNC, 8'h80);
      wr(`FWG_OFS_MODE, 8'h00);
      kcall(`FWG_FN_VERSION, 8'h00, 8'h00, 1'b0, 3'd0);
      crd(`FWG_OFS_FUNC, `FWG_VERSION_ID);
      crd(`FWG_OFS_KEY, 8'h00);
      done("config protect");
      // First pass reuses a spent key, second writes a wrong one.
      for (i = 0; i < 2; i++)
      begin
         if (i == 1)
            wr(`FWG_OFS_KEY, 8'($urandom_range(0, 149)));
         wr(`FWG_OFS_FUNC, `FWG_FN_ERASE);
         @(negedge clk);
         chk({7'h00, mcu_reset_req}, 8'h01);
         @(posedge clk);
         resetn <= 1'b0;
         repeat (2) @(posedge clk);
         resetn <= 1'b1;
         crd(`FWG_OFS_STATUS, 8'h40);
      end
      done("key");
      summarize();
   end
   // The run takes under a thousand cycles; this only trips on a hang.
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end
endmodule
`default_nettype wire
